// ===== shared/led_pwm_pkg.sv
// Function
// - scale codes 10h-13h on, 00h-0Fh off
// - twelve control registers, first is output one
// - global disable bit forces all outputs off
// - frequency bit picks 24 kHz or 3.6 kHz
// - zero write to reset register restores defaults
// - power-up reset loads defaults, outputs dark
// - each channel has 8-bit 256-step duty
// - duty value equals on-steps per period
// - each channel scale set independently
// - duty and control shadowed until update write
// - average current is scale times duty/256
// - sleep bit low switches all outputs off
package led_pwm_pkg;
	// register map
	localparam logic [7:0] ADDR_SLEEP      = 8'h00;
	localparam logic [7:0] ADDR_DUTY_FIRST = 8'h04;
	localparam logic [7:0] ADDR_UPDATE     = 8'h13;
	localparam logic [7:0] ADDR_CTRL_FIRST = 8'h17;
	localparam logic [7:0] ADDR_GLOBAL     = 8'h26;
	localparam logic [7:0] ADDR_FREQ       = 8'h27;
	localparam logic [7:0] ADDR_RESET      = 8'h2f;
	// trigger value for update and reset writes
	localparam logic [7:0] TRIGGER_CODE = 8'h00;
	// defaults of every register
	localparam logic [7:0] DUTY_DEFAULT = 8'h00;
	localparam logic [5:0] CTRL_DEFAULT = 6'h00;
	localparam logic       FLAG_DEFAULT = 1'b0;
	// field layout
	localparam int FLAG_BIT = 0;
	localparam int CTRL_MSB = 5;
	// current scale codes
	localparam logic [5:0] SCALE_FULL = 6'h10;
	localparam logic [5:0] SCALE_SEVEN = 6'h13;
	localparam logic [1:0] LEVEL_OFF = 2'h0;
	// timing
	localparam longint CLK_HZ      = 100_000_000;
	localparam longint PWM_FAST_HZ = 24000;
	localparam longint PWM_SLOW_HZ = 3600;
	localparam longint PWM_STEPS   = 256;
	localparam logic [7:0] FAST_DIV = 8'(CLK_HZ / (PWM_FAST_HZ * PWM_STEPS));
	localparam logic [7:0] SLOW_DIV = 8'(CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS));
	localparam logic [7:0] COUNT_LAST = 8'hff;

	// legal on code test
	function automatic logic is_on(input logic [5:0] code);
		return (code >= SCALE_FULL) && (code <= SCALE_SEVEN);
	endfunction
endpackage

// ===== shared/pwm_timebase_if.sv
`timescale 1ns/1ns
// shared pwm timebase between register logic and counter
interface pwm_timebase_if;
	logic       freq_sel;     // 0 fast, 1 slow
	logic [7:0] count;        // shared step counter
	logic       tick;         // one pulse per step
	logic       period_start; // pulse at count wrap
	modport gen (input freq_sel, output count, output tick, output period_start);
	modport use_side (output freq_sel, input count, input tick, input period_start);
endinterface

// ===== src/pwm_timebase.sv
`timescale 1ns/1ns
module pwm_timebase (
	input  wire logic   CLOCK,
	input  wire logic   RST,
	pwm_timebase_if.gen tb
);
	logic [7:0] div_r;   // prescaler
	logic [7:0] count_r; // step counter
	logic [7:0] limit;   // prescale length
	logic       tick;    // step boundary
	logic [7:0] gap_r;   // helper: cycles since tick

	////////////////////////////////////////////////////////////////////////
	// prescaler sized by selected frequency
	assign limit = tb.freq_sel ? led_pwm_pkg::SLOW_DIV : led_pwm_pkg::FAST_DIV;
	assign tick  = (div_r >= limit - 8'h01);

	// prescale divider
	always_ff @(posedge CLOCK) begin
		if (RST)
			div_r <= 8'h00;
		else if (tick)
			div_r <= 8'h00;
		else
			div_r <= div_r + 8'h01;
	end

	// one counter for every channel
	always_ff @(posedge CLOCK) begin
		if (RST)
			count_r <= 8'h00;
		else if (tick)
			count_r <= count_r + 8'h01;
	end

	assign tb.count        = count_r;
	assign tb.tick         = tick;
	assign tb.period_start = tick && (count_r == led_pwm_pkg::COUNT_LAST);

	////////////////////////////////////////////////////////////////////////
	// helper gap counter for step spacing
	always_ff @(posedge CLOCK) begin
		if (RST || tick)
			gap_r <= 8'h00;
		else
			gap_r <= gap_r + 8'h01;
	end

	a_fast_step: assert property (@(posedge CLOCK) disable iff (RST)
		(tick && !tb.freq_sel && $stable(tb.freq_sel) && !$past(RST))
		|-> gap_r == led_pwm_pkg::FAST_DIV - 8'h01)
		else $error("fast step spacing wrong");
	a_count_advance: assert property (@(posedge CLOCK) disable iff (RST)
		tick |=> count_r == $past(count_r) + 8'h01)
		else $error("counter did not advance");
	c_slow_period: cover property (@(posedge CLOCK) disable iff (RST)
		tb.freq_sel && tb.period_start);
endmodule // pwm_timebase

// ===== src/led_channel_current_pwm_ctrl.sv
`timescale 1ns/1ns
module led_channel_current_pwm_ctrl #(
	parameter int NUM_CH = 12 // channel count
) (
	input  wire logic                CLOCK,
	input  wire logic                RST,
	input  wire logic                WR_STROBE,
	input  wire logic [7:0]          WR_ADDR,
	input  wire logic [7:0]          WR_DATA,
	output logic [NUM_CH-1:0]        LED_SINK_OUTPUTS,
	output logic [2*NUM_CH-1:0]      CURRENT_SCALE_CODE,
	output logic                     PWM_FREQ_SEL
);
	////////////////////////////////////////////////////////////////////////
	// elaboration check: channel span fixed by the map
	if (NUM_CH < 1 || NUM_CH > 12) begin : g_bad_ch
		$error("NUM_CH must be 1 to 12");
	end

	////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0] duty_sh_r [NUM_CH]; // shadow duty
	logic [5:0] ctrl_sh_r [NUM_CH]; // shadow scale code
	logic [7:0] duty_r    [NUM_CH]; // live duty
	logic [5:0] ctrl_r    [NUM_CH]; // live scale code
	logic       soft_sleep_n_r;     // 0 sleeps, 1 runs
	logic       global_off_r;       // 1 forces dark
	logic       pwm_freq_sel_r;     // 0 fast, 1 slow
	logic [NUM_CH-1:0]   led_r;     // registered sinks
	logic [2*NUM_CH-1:0] scale_r;   // registered scale

	// decoded writes
	logic wr_sleep;  // sleep register write
	logic wr_global; // global disable write
	logic wr_freq;   // frequency write
	logic wr_update; // update trigger
	logic wr_reset;  // soft reset trigger
	logic run;       // all gates open

	pwm_timebase_if tbi ();

	////////////////////////////////////////////////////////////////////////
	// channel index from address, range checked
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		return (a >= base) && (a < base + 8'(NUM_CH));
	endfunction

	function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base);
		return int'(a - base);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// single register decode
	assign wr_sleep  = WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_SLEEP);
	assign wr_global = WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_GLOBAL);
	assign wr_freq   = WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_FREQ);
	// only an all-zero write triggers
	assign wr_update = WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_UPDATE)
		&& (WR_DATA == led_pwm_pkg::TRIGGER_CODE);
	assign wr_reset  = WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_RESET)
		&& (WR_DATA == led_pwm_pkg::TRIGGER_CODE);

	////////////////////////////////////////////////////////////////////////
	// sleep flag, retains channel data while low
	always_ff @(posedge CLOCK) begin
		if (RST || wr_reset)
			soft_sleep_n_r <= led_pwm_pkg::FLAG_DEFAULT;
		else if (wr_sleep)
			soft_sleep_n_r <= WR_DATA[led_pwm_pkg::FLAG_BIT];
	end

	// global disable flag
	always_ff @(posedge CLOCK) begin
		if (RST || wr_reset)
			global_off_r <= led_pwm_pkg::FLAG_DEFAULT;
		else if (wr_global)
			global_off_r <= WR_DATA[led_pwm_pkg::FLAG_BIT];
	end

	// frequency select, applies to all channels
	always_ff @(posedge CLOCK) begin
		if (RST || wr_reset)
			pwm_freq_sel_r <= led_pwm_pkg::FLAG_DEFAULT;
		else if (wr_freq)
			pwm_freq_sel_r <= WR_DATA[led_pwm_pkg::FLAG_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// shadow duty: host may rewrite any time
	always_ff @(posedge CLOCK) begin
		if (RST || wr_reset) begin
			for (int i = 0; i < NUM_CH; i++)
				duty_sh_r[i] <= led_pwm_pkg::DUTY_DEFAULT;
		end else if (WR_STROBE && in_bank(WR_ADDR, led_pwm_pkg::ADDR_DUTY_FIRST)) begin
			duty_sh_r[bank_idx(WR_ADDR, led_pwm_pkg::ADDR_DUTY_FIRST)] <= WR_DATA;
		end
	end

	// shadow scale code: one register per output, in order
	always_ff @(posedge CLOCK) begin
		if (RST || wr_reset) begin
			for (int i = 0; i < NUM_CH; i++)
				ctrl_sh_r[i] <= led_pwm_pkg::CTRL_DEFAULT;
		end else if (WR_STROBE && in_bank(WR_ADDR, led_pwm_pkg::ADDR_CTRL_FIRST)) begin
			ctrl_sh_r[bank_idx(WR_ADDR, led_pwm_pkg::ADDR_CTRL_FIRST)]
				<= WR_DATA[led_pwm_pkg::CTRL_MSB:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// live copies load only on update trigger
	always_ff @(posedge CLOCK) begin
		if (RST || wr_reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_r[i] <= led_pwm_pkg::DUTY_DEFAULT;
				ctrl_r[i] <= led_pwm_pkg::CTRL_DEFAULT;
			end
		end else if (wr_update) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_r[i] <= duty_sh_r[i];
				ctrl_r[i] <= ctrl_sh_r[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared timebase
	assign tbi.freq_sel = pwm_freq_sel_r;

	pwm_timebase u_timebase (
		.CLOCK (CLOCK),
		.RST   (RST),
		.tb    (tbi.gen)
	);

	////////////////////////////////////////////////////////////////////////
	// output gating
	assign run = soft_sleep_n_r && !global_off_r;

	// sinks conduct for duty steps of each period
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			led_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++)
				led_r[i] <= run && led_pwm_pkg::is_on(ctrl_r[i])
					&& (tbi.count < duty_r[i]);
		end
	end

	// active current scale, zero when off
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			scale_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++)
				scale_r[2*i +: 2] <= led_pwm_pkg::is_on(ctrl_r[i])
					? ctrl_r[i][1:0] : led_pwm_pkg::LEVEL_OFF;
		end
	end

	assign LED_SINK_OUTPUTS   = led_r;
	assign CURRENT_SCALE_CODE = scale_r;
	assign PWM_FREQ_SEL       = pwm_freq_sel_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_sleep_dark: assert property (@(posedge CLOCK) disable iff (RST)
		!soft_sleep_n_r |=> LED_SINK_OUTPUTS == '0)
		else $error("output lit while asleep");

	a_global_dark: assert property (@(posedge CLOCK) disable iff (RST)
		global_off_r |=> LED_SINK_OUTPUTS == '0)
		else $error("output lit while globally off");

	a_reset_dark: assert property (@(posedge CLOCK)
		RST |=> (LED_SINK_OUTPUTS == '0) && !soft_sleep_n_r && (duty_r[0] == 8'h00))
		else $error("reset left state not default");

	a_soft_reset: assert property (@(posedge CLOCK) disable iff (RST)
		wr_reset |=> !soft_sleep_n_r && !global_off_r && !pwm_freq_sel_r
			&& (duty_sh_r[0] == 8'h00) && (ctrl_r[0] == 6'h00))
		else $error("soft reset missed a register");

	a_shadow_hold: assert property (@(posedge CLOCK) disable iff (RST)
		!wr_update && !wr_reset |=> (duty_r[0] == $past(duty_r[0]))
			&& (ctrl_r[0] == $past(ctrl_r[0])))
		else $error("live value changed without update");

	a_update_load: assert property (@(posedge CLOCK) disable iff (RST)
		wr_update |=> (duty_r[0] == $past(duty_sh_r[0]))
			&& (ctrl_r[0] == $past(ctrl_sh_r[0])))
		else $error("update did not load shadow");

	a_ctrl_last: assert property (@(posedge CLOCK) disable iff (RST)
		WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_CTRL_FIRST + 8'(NUM_CH-1))
		|=> ctrl_sh_r[NUM_CH-1] == $past(WR_DATA[5:0]))
		else $error("last control register misplaced");

	a_duty_step: assert property (@(posedge CLOCK) disable iff (RST)
		run && led_pwm_pkg::is_on(ctrl_r[0])
		|=> LED_SINK_OUTPUTS[0] == ($past(tbi.count) < $past(duty_r[0])))
		else $error("channel 0 on-time wrong");

	a_illegal_off: assert property (@(posedge CLOCK) disable iff (RST)
		!led_pwm_pkg::is_on(ctrl_r[0])
		|=> !LED_SINK_OUTPUTS[0] && (scale_r[1:0] == led_pwm_pkg::LEVEL_OFF))
		else $error("off code lit channel 0");

	////////////////////////////////////////////////////////////////////////
	// register write checks

	// written flags reach their registers at the next edge
	a_sleep_write: assert property (@(posedge CLOCK) disable iff (RST)
		wr_sleep |=> soft_sleep_n_r == $past(WR_DATA[led_pwm_pkg::FLAG_BIT]))
		else $error("sleep bit not taken");

	a_global_write: assert property (@(posedge CLOCK) disable iff (RST)
		wr_global |=> global_off_r == $past(WR_DATA[led_pwm_pkg::FLAG_BIT]))
		else $error("global disable bit not taken");

	// the frequency pin shows the written bit from the next edge
	a_freq_write: assert property (@(posedge CLOCK) disable iff (RST)
		wr_freq |=> PWM_FREQ_SEL == $past(WR_DATA[led_pwm_pkg::FLAG_BIT]))
		else $error("frequency bit not taken");

	// a reset register write with nonzero data changes nothing
	a_reset_refused: assert property (@(posedge CLOCK) disable iff (RST)
		WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_RESET) && !wr_reset
		|=> $stable(soft_sleep_n_r) && $stable(global_off_r) && $stable(pwm_freq_sel_r)
			&& (duty_sh_r[0] == $past(duty_sh_r[0])) && (ctrl_r[0] == $past(ctrl_r[0])))
		else $error("refused reset changed state");

	// first address of the duty bank lands in channel 0
	a_duty_first: assert property (@(posedge CLOCK) disable iff (RST)
		WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_DUTY_FIRST)
		|=> duty_sh_r[0] == $past(WR_DATA))
		else $error("first duty register misplaced");

	// the last duty address lands in the last channel
	a_duty_last: assert property (@(posedge CLOCK) disable iff (RST)
		WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_DUTY_FIRST + 8'(NUM_CH-1))
		|=> duty_sh_r[NUM_CH-1] == $past(WR_DATA))
		else $error("last duty register misplaced");

	// first address of the control bank lands in channel 0
	a_ctrl_first: assert property (@(posedge CLOCK) disable iff (RST)
		WR_STROBE && (WR_ADDR == led_pwm_pkg::ADDR_CTRL_FIRST)
		|=> ctrl_sh_r[0] == $past(WR_DATA[led_pwm_pkg::CTRL_MSB:0]))
		else $error("first control register misplaced");

	// asleep with no writes, stored values stay put
	a_sleep_keep: assert property (@(posedge CLOCK) disable iff (RST)
		!soft_sleep_n_r && !WR_STROBE
		|=> (duty_sh_r[0] == $past(duty_sh_r[0])) && (duty_r[0] == $past(duty_r[0])))
		else $error("contents lost while asleep");

	// a legal live code drives its low bits onto the scale output
	a_scale_legal: assert property (@(posedge CLOCK) disable iff (RST)
		led_pwm_pkg::is_on(ctrl_r[0]) |=> scale_r[1:0] == $past(ctrl_r[0][1:0]))
		else $error("scale code wrong on channel 0");

	// the shared counter moves only on a step tick
	a_count_hold: assert property (@(posedge CLOCK) disable iff (RST)
		!tbi.tick |=> tbi.count == $past(tbi.count))
		else $error("counter moved between steps");

	// every period starts from step zero for all channels
	a_period_wrap: assert property (@(posedge CLOCK) disable iff (RST)
		tbi.period_start |=> tbi.count == '0)
		else $error("counter did not wrap at period start");

	////////////////////////////////////////////////////////////////////////
	// per-channel checks, one set for every output
	for (genvar g = 0; g < NUM_CH; g++) begin : g_chan_chk
		// on-time follows the shared count and the live duty
		a_chan_step: assert property (@(posedge CLOCK) disable iff (RST)
			run && led_pwm_pkg::is_on(ctrl_r[g])
			|=> LED_SINK_OUTPUTS[g] == ($past(tbi.count) < $past(duty_r[g])))
			else $error("channel on-time wrong");

		// sleep, global disable and off codes keep the sink dark
		a_chan_dark: assert property (@(posedge CLOCK) disable iff (RST)
			!run || !led_pwm_pkg::is_on(ctrl_r[g]) |=> !LED_SINK_OUTPUTS[g])
			else $error("channel lit while off");

		// off codes report the off level on the scale output
		a_chan_scale: assert property (@(posedge CLOCK) disable iff (RST)
			!led_pwm_pkg::is_on(ctrl_r[g])
			|=> CURRENT_SCALE_CODE[2*g +: 2] == led_pwm_pkg::LEVEL_OFF)
			else $error("off channel shows a scale");

		// live values move only on update or reset
		a_chan_hold: assert property (@(posedge CLOCK) disable iff (RST)
			!wr_update && !wr_reset
			|=> (duty_r[g] == $past(duty_r[g])) && (ctrl_r[g] == $past(ctrl_r[g])))
			else $error("live value changed without update");

		// update copies every shadow at once
		a_chan_load: assert property (@(posedge CLOCK) disable iff (RST)
			wr_update
			|=> (duty_r[g] == $past(duty_sh_r[g])) && (ctrl_r[g] == $past(ctrl_sh_r[g])))
			else $error("update missed a channel");
	end

	c_update: cover property (@(posedge CLOCK) disable iff (RST) wr_update);
	c_light: cover property (@(posedge CLOCK) disable iff (RST) $rose(LED_SINK_OUTPUTS[0]));
	c_soft_reset: cover property (@(posedge CLOCK) disable iff (RST) wr_reset && run);
	c_all_on: cover property (@(posedge CLOCK) disable iff (RST) &LED_SINK_OUTPUTS);
endmodule // led_channel_current_pwm_ctrl

// ===== verif/host_writer_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
// host side writer: one byte per strobe, driven after a falling edge
module host_writer_model (
	input  wire logic  CLOCK,
	output logic       WR_STROBE,
	output logic [7:0] WR_ADDR,
	output logic [7:0] WR_DATA
);
	// 32-step gamma ramp used for a breathing cycle
	logic [7:0] gamma_table [32] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0a,
		8'h0d, 8'h12, 8'h16, 8'h1c, 8'h21, 8'h27, 8'h2e, 8'h35, 8'h3d, 8'h45, 8'h4e, 8'h56,
		8'h60, 8'h6a, 8'h74, 8'h7e, 8'h8a, 8'h95, 8'ha1, 8'had, 8'hba, 8'hc7, 8'hd4, 8'he2,
		8'hf0, 8'hff};
	// idle bus at time zero
	initial begin
		WR_STROBE = 1'b0;
		WR_ADDR   = 8'h00;
		WR_DATA   = 8'h00;
	end
	// entered at a falling edge; strobe stays up when another byte follows
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic last);
		WR_STROBE = 1'b1;
		WR_ADDR   = a;
		WR_DATA   = d;
		@(negedge CLOCK);
		if (last) begin
			// released lines must not keep showing the old byte
			WR_STROBE = 1'b0;
			WR_ADDR   = ~a;
			WR_DATA   = ~d;
			// one idle edge so the next strobe is a fresh rise
			@(negedge CLOCK);
		end
	endtask
	// rewrite one duty register along the ramp, latching each step
	task automatic breathe(input logic [7:0] duty_addr);
		for (int k = 0; k < 32; k++) begin
			write_reg(duty_addr, gamma_table[k], 1'b0);
			write_reg(led_pwm_pkg::ADDR_UPDATE, led_pwm_pkg::TRIGGER_CODE, 1'b1);
			repeat (4) @(negedge CLOCK);
		end
	endtask
endmodule // host_writer_model

// ===== verif/led_channel_current_pwm_ctrl_tb_top.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
// self-checking bench for the led pwm register block
module led_channel_current_pwm_ctrl_tb_top;
	logic        clock;       // 100 MHz
	logic        rst;         // sync reset
	logic        wr_strobe;   // from host model
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [11:0] led;         // sink outputs
	logic [23:0] scale;       // live scale codes
	logic        freq;        // live frequency bit
	int          miscompares = 0;
	int          num_checks = 0;
	int          order_bad = 0;   // shorter pulse seen outside longer one
	int          hi_cnt [12];     // high samples per channel
	// per-channel duty and control written by the bench
	logic [7:0]  duty_v [12] = '{8'h80, 8'h04, 8'h40, 8'hff, 8'h20, 8'h20, 8'h20, 8'h20,
		8'h20, 8'h00, 8'h01, 8'hff};
	logic [7:0]  ctrl_v [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h00, 8'h0f, 8'h14, 8'h3f,
		8'h10, 8'h11, 8'h12, 8'h13};
	////////////////////////////////////////////////////////////////
	led_channel_current_pwm_ctrl #(.NUM_CH(12)) led_channel_current_pwm_ctrl_i (
		.CLOCK(clock), .RST(rst), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr),
		.WR_DATA(wr_data), .LED_SINK_OUTPUTS(led), .CURRENT_SCALE_CODE(scale),
		.PWM_FREQ_SEL(freq));
	host_writer_model host_writer_model_i (
		.CLOCK(clock), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
	////////////////////////////////////////////////////////////////
	// clock generator
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// compare and count
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	// single write ending with the strobe dropped
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_writer_model_i.write_reg(a, d, 1'b1);
	endtask
	// count high samples of every output over n cycles
	task automatic measure(input int n);
		hi_cnt = '{default: 0};
		repeat (n) begin
			@(negedge clock);
			for (int c = 0; c < 12; c++) hi_cnt[c] += int'(led[c] === 1'b1);
			if (led[1] === 1'b1 && led[0] !== 1'b1) order_bad++;
		end
	endtask
	// expected high time is duty times clocks per step for legal on codes
	task automatic check_counts(input int div, input logic run);
		logic on;
		for (int c = 0; c < 12; c++) begin
			on = (ctrl_v[c] >= 8'h10) && (ctrl_v[c] <= 8'h13);
			check(hi_cnt[c], (run && on) ? duty_v[c] * div : 0, "high time");
			if (run) check(scale[2*c +: 2], on ? ctrl_v[c][1:0] : 2'h0, "scale code");
		end
	endtask
	// verdict
	task automatic results();
		$display("num_checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		repeat (10) @(negedge clock);
		check({led, scale, freq}, 37'h0, "reset state");
		rst = 1'b0;
		// back-to-back writes to every duty and control register
		for (int c = 0; c < 12; c++) begin
			host_writer_model_i.write_reg(8'h04 + 8'(c), duty_v[c], 1'b0);
			host_writer_model_i.write_reg(8'h17 + 8'(c), ctrl_v[c], 1'b0);
		end
		host_writer_model_i.write_reg(8'h00, 8'h01, 1'b1);
		measure(300);
		check_counts(16, 1'b0);
		wr(8'h13, 8'h00);
		repeat (4) @(negedge clock);
		measure(4096);
		check_counts(16, 1'b1);
		check(order_bad, 0, "shared timebase");
		// global disable then release
		wr(8'h26, 8'h01);
		measure(4096);
		check_counts(16, 1'b0);
		wr(8'h26, 8'h00);
		// sleep; a shadow duty write and refused writes meanwhile; wake keeps contents
		wr(8'h00, 8'h00);
		measure(4096);
		check_counts(16, 1'b0);
		wr(8'h04, 8'h10);
		wr(8'h13, 8'h55);
		wr(8'h2f, 8'h01);
		wr(8'h30, 8'h01);
		wr(8'h00, 8'h01);
		repeat (4) @(negedge clock);
		measure(4096);
		check_counts(16, 1'b1);
		// breathing ramp ends on full duty
		host_writer_model_i.breathe(8'h04);
		duty_v[0] = 8'hff;
		measure(4096);
		check_counts(16, 1'b1);
		// slow frequency, one period to settle
		wr(8'h27, 8'h01);
		check(freq, 1'b1, "frequency bit");
		repeat (27648) @(negedge clock);
		measure(27648);
		check_counts(108, 1'b1);
		// soft reset clears live and shadow state; wr leaves two edges for the outputs
		wr(8'h2f, 8'h00);
		check({led, scale, freq}, 37'h0, "soft reset");
		wr(8'h13, 8'h00);
		wr(8'h00, 8'h01);
		measure(300);
		check_counts(16, 1'b0);
		results();
	end
endmodule // led_channel_current_pwm_ctrl_tb_top
